// >>> src/tcc_pkg.sv
// Package of constants and types for the timer capture/compare block.
package tcc_pkg;
    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int CH_COUNT = 4;
    localparam int CH_BASE = 4;
    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [6:0] PRE_RESET = 7'h00;
    localparam logic [5:0] GATE_DIV_LAST = 6'h3F;
    localparam int CH7_IDX = 3;
    // ------------------------------------------------------------------
    // Compare action encoding {mode bit, level bit}
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TCC_ACT_OFF = 2'b00,
        TCC_ACT_TOGGLE = 2'b01,
        TCC_ACT_CLEAR = 2'b10,
        TCC_ACT_SET = 2'b11
    } tcc_action_t;
endpackage

// >>> src/tcc_timer.sv
// Four-channel 16-bit timer with capture, compare and pulse accumulator.
module tcc_timer
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timer control
    input wire logic timerEnable,
    input wire logic [2:0] clockDivisorSelect,
    input wire logic counterResetOnCh7Enable,
    input wire logic fastFlagClearEnable,
    input wire logic counterOverflowFlagClear,
    // Channel control
    input wire logic [3:0] channelDirectionSelect,
    input wire logic [3:0] compareActionModeBit,
    input wire logic [3:0] compareActionLevelBit,
    input wire logic [3:0] captureEdgeRising,
    input wire logic [3:0] captureEdgeFalling,
    input wire logic [3:0] forceCompareBit,
    input wire logic [3:0] channelIrqEnable,
    input wire logic [3:0] channelEventFlagClear,
    input wire logic [3:0] ch7CompareMask,
    input wire logic [3:0] ch7CompareData,
    input wire logic [63:0] channelWriteValue,
    input wire logic [3:0] channelWriteStrobe,
    input wire logic [3:0] portWriteValue,
    input wire logic [3:0] portWriteStrobe,
    // Accumulator control
    input wire logic accumulatorEnable,
    input wire logic accumulatorModeBit,
    input wire logic accumulatorEdgeSelect,
    input wire logic accumulatorOverflowIrqEnable,
    input wire logic accumulatorInputIrqEnable,
    input wire logic [1:0] accumulatorFlagClear,
    input wire logic accumulatorCountAccess,
    input wire logic [15:0] accumulatorWriteValue,
    input wire logic accumulatorWriteStrobe,
    // Pins
    input wire logic [3:0] channelPinIn,
    output logic [3:0] channelPinOut,
    // Status
    output logic [15:0] timerCount,
    output logic [63:0] channelRegister,
    output logic [3:0] channelEventFlag,
    output logic counterOverflowFlag,
    output logic [15:0] accumulatorCount,
    output logic [1:0] accumulatorFlagRegister,
    // Interrupt requests
    output logic [3:0] channelIrq,
    output logic accumulatorInputIrq,
    output logic accumulatorOverflowIrq,
    output logic counterOverflowIrq
);
    import tcc_pkg::*;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] pinMeta_reg, pinSync_reg, pinLast_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            pinMeta_reg <= 4'h0;
            pinSync_reg <= 4'h0;
            pinLast_reg <= 4'h0;
        end else begin
            pinMeta_reg <= channelPinIn;
            pinSync_reg <= pinMeta_reg;
            pinLast_reg <= pinSync_reg;
        end
    end
    logic [3:0] pinRise, pinFall;
    assign pinRise = pinSync_reg & ~pinLast_reg;
    assign pinFall = ~pinSync_reg & pinLast_reg;

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    logic [6:0] pre_reg;
    logic [6:0] preMask;
    logic preTick;
    always_ff @(posedge clk) begin
        if (rst || !timerEnable) begin
            pre_reg <= PRE_RESET;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end
    assign preMask = 7'((8'h01 << clockDivisorSelect) - 8'h01);
    assign preTick = timerEnable && ((pre_reg & preMask) == preMask);

    // The gating clock counts prescaler ticks, so it dies with the timer.
    logic [5:0] gateDiv_reg;
    logic gateTick;
    always_ff @(posedge clk) begin
        if (rst || !timerEnable) begin
            gateDiv_reg <= 6'h00;
        end else if (preTick) begin
            gateDiv_reg <= gateDiv_reg + 6'h01;
        end
    end
    assign gateTick = preTick && (gateDiv_reg == GATE_DIV_LAST);

    // ------------------------------------------------------------------
    // Compare matches and capture events
    // ------------------------------------------------------------------
    logic [15:0] count_reg;
    logic [3:0] match;
    logic [3:0] capture;
    for (genvar i = 0; i < CH_COUNT; i++) begin : gMatch
        assign match[i] = preTick && channelDirectionSelect[i]
            && (count_reg == channelRegister[16*i +: 16]);
        assign capture[i] = !channelDirectionSelect[i]
            && ((pinRise[i] && captureEdgeRising[i])
            || (pinFall[i] && captureEdgeFalling[i]));
    end
    logic ch7Match;
    assign ch7Match = match[CH7_IDX];

    // ------------------------------------------------------------------
    // Main counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= CNT_RESET;
        end else if (ch7Match && counterResetOnCh7Enable) begin
            count_reg <= CNT_RESET;
        end else if (preTick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end
    assign timerCount = count_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            counterOverflowFlag <= 1'b0;
        end else if (preTick && count_reg == CNT_MAX
                && !(ch7Match && counterResetOnCh7Enable)) begin
            counterOverflowFlag <= 1'b1;
        end else if (counterOverflowFlagClear) begin
            counterOverflowFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    logic [3:0] pinOut_reg, portLatch_reg;
    for (genvar i = 0; i < CH_COUNT; i++) begin : gChan
        logic [1:0] act;
        logic owned;
        logic compareLevel;
        assign act = {compareActionModeBit[i], compareActionLevelBit[i]};
        assign owned = channelDirectionSelect[i] && act != TCC_ACT_OFF;

        always_comb begin
            compareLevel = pinOut_reg[i];
            case (act)
                TCC_ACT_TOGGLE: compareLevel = ~pinOut_reg[i];
                TCC_ACT_CLEAR: compareLevel = 1'b0;
                TCC_ACT_SET: compareLevel = 1'b1;
                default: compareLevel = pinOut_reg[i];
            endcase
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                channelRegister[16*i +: 16] <= CNT_RESET;
            end else if (capture[i]) begin
                channelRegister[16*i +: 16] <= count_reg;
            end else if (channelWriteStrobe[i]) begin
                channelRegister[16*i +: 16] <= channelWriteValue[16*i +: 16];
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                channelEventFlag[i] <= 1'b0;
            end else if (capture[i] || match[i]) begin
                channelEventFlag[i] <= 1'b1;
            end else if (channelEventFlagClear[i]) begin
                channelEventFlag[i] <= 1'b0;
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                portLatch_reg[i] <= 1'b0;
            end else if (portWriteStrobe[i]) begin
                portLatch_reg[i] <= portWriteValue[i];
            end
        end

        // Channel 7 override comes first; its own action loses to it.
        always_ff @(posedge clk) begin
            if (rst) begin
                pinOut_reg[i] <= 1'b0;
            end else if (ch7Match && ch7CompareMask[i]) begin
                pinOut_reg[i] <= ch7CompareData[i];
            end else if (owned && (match[i] || forceCompareBit[i])) begin
                pinOut_reg[i] <= compareLevel;
            end else if (!owned && !ch7CompareMask[i]) begin
                pinOut_reg[i] <= portLatch_reg[i];
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                channelIrq[i] <= 1'b0;
            end else begin
                channelIrq[i] <= channelEventFlag[i] && channelIrqEnable[i];
            end
        end
    end
    assign channelPinOut = pinOut_reg;

    // ------------------------------------------------------------------
    // Pulse accumulator
    // ------------------------------------------------------------------
    logic accPin, accPinLast;
    logic accActive, accTrailing, accEdge, accStep, accWrap;
    assign accPin = pinSync_reg[CH7_IDX];
    assign accPinLast = pinLast_reg[CH7_IDX];
    // Zero selects falling edge or high level, one rising or low.
    assign accEdge = accumulatorEdgeSelect ? (accPin && !accPinLast)
        : (!accPin && accPinLast);
    assign accActive = accPin ^ accumulatorEdgeSelect;
    assign accTrailing = accumulatorEdgeSelect ? (accPin && !accPinLast)
        : (!accPin && accPinLast);
    // A software write to the count wins over a step in the same cycle.
    assign accStep = !accumulatorWriteStrobe && accumulatorEnable
        && (accumulatorModeBit
        ? (gateTick && accActive)
        : accEdge);
    assign accWrap = accStep && accumulatorCount == CNT_MAX;

    always_ff @(posedge clk) begin
        if (rst) begin
            accumulatorCount <= CNT_RESET;
        end else if (accumulatorWriteStrobe) begin
            accumulatorCount <= accumulatorWriteValue;
        end else if (accStep) begin
            accumulatorCount <= accumulatorCount + 16'h0001;
        end
    end

    // Set wins over a clear in the same cycle so no event is lost.
    logic fastClear;
    assign fastClear = fastFlagClearEnable && accumulatorCountAccess;
    always_ff @(posedge clk) begin
        if (rst) begin
            accumulatorFlagRegister <= 2'b00;
        end else begin
            if (accWrap) begin
                accumulatorFlagRegister[1] <= 1'b1;
            end else if (accumulatorFlagClear[1] || fastClear) begin
                accumulatorFlagRegister[1] <= 1'b0;
            end
            if (accumulatorEnable && (accumulatorModeBit ? accTrailing
                    : accEdge)) begin
                accumulatorFlagRegister[0] <= 1'b1;
            end else if (accumulatorFlagClear[0] || fastClear) begin
                accumulatorFlagRegister[0] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt requests
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            accumulatorInputIrq <= 1'b0;
            accumulatorOverflowIrq <= 1'b0;
            counterOverflowIrq <= 1'b0;
        end else begin
            accumulatorInputIrq <= accumulatorFlagRegister[0]
                && accumulatorInputIrqEnable;
            accumulatorOverflowIrq <= accumulatorFlagRegister[1]
                && accumulatorOverflowIrqEnable;
            counterOverflowIrq <= counterOverflowFlag;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    capture_copy_a: assert property (capture[0] |=>
        channelRegister[15:0] == $past(count_reg))
        else $error("Capture did not copy the counter.");
    capture_flag_a: assert property (capture[0]
        |=> channelEventFlag[0])
        else $error("Capture did not set the flag.");
    compare_flag_a: assert property (match[1]
        |=> channelEventFlag[1])
        else $error("Compare did not set the flag.");
    ch7_override_a: assert property (ch7Match && ch7CompareMask[0]
        |=> channelPinOut[0] == $past(ch7CompareData[0]))
        else $error("Channel seven override failed.");
    counter_reset_a: assert property (ch7Match
        && counterResetOnCh7Enable |=> timerCount == 16'h0000)
        else $error("Counter reset on channel seven failed.");
    acc_wrap_a: assert property (accWrap
        |=> accumulatorCount == 16'h0000 && accumulatorFlagRegister[1])
        else $error("Accumulator wrap not flagged.");
    acc_event_a: assert property (accEdge && accumulatorEnable
        && !accumulatorModeBit && !accumulatorWriteStrobe
        |=> accumulatorCount == $past(accumulatorCount) + 16'h0001)
        else $error("Event edge not counted.");
    gate_stop_a: assert property (!timerEnable && accumulatorModeBit
        && !accumulatorWriteStrobe |=> $stable(accumulatorCount))
        else $error("Gated count moved with timer off.");
    prescale_a: assert property (clockDivisorSelect == 3'h1
        && timerEnable && $stable(clockDivisorSelect) && preTick |=> !preTick)
        else $error("Prescaler divide by two wrong.");
    irq_gate_a: assert property (accumulatorFlagRegister[0]
        && accumulatorInputIrqEnable |=> accumulatorInputIrq)
        else $error("Input request missing.");
    flag_clear_a: assert property (fastClear && !accWrap
        |=> !accumulatorFlagRegister[1])
        else $error("Fast clear failed.");

    capture_seen_c: cover property (capture[0]);
    compare_seen_c: cover property (match[1]);
    acc_wrap_c: cover property (accWrap);
    gated_count_c: cover property (accumulatorModeBit && accStep);
endmodule

// >>> tb/tcc_pin_model.sv
// Model of the outside world that drives the timer's event pins.
module tcc_pin_model
    import tcc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Levels asked for by the bench
    input wire logic [3:0] pinReq,
    // Pins as the timer sees them
    output logic [3:0] pinOut
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] holdCnt;
    initial begin
        pinOut = 4'h0;
        holdCnt = 2'h0;
    end
    // A new level waits until the old one stood four clocks, so no
    // pulse is ever short enough for the synchronizer to lose it.
    always @(posedge clk) begin
        if (holdCnt != 2'h3) begin
            holdCnt <= holdCnt + 2'h1;
        end else if (pinReq != pinOut) begin
            pinOut <= pinReq;
            holdCnt <= 2'h0;
        end
    end
endmodule

// >>> tb/tcc_timer_tb_top.sv
// Self-checking testbench for the four-channel timer block.
module tcc_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tcc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic timerEnable, counterResetOnCh7Enable, fastFlagClearEnable;
    logic counterOverflowFlagClear, accumulatorEnable, accumulatorModeBit;
    logic accumulatorEdgeSelect, accumulatorOverflowIrqEnable;
    logic accumulatorInputIrqEnable, accumulatorCountAccess;
    logic counterOverflowFlag, accumulatorInputIrq, accumulatorOverflowIrq;
    logic counterOverflowIrq, accumulatorWriteStrobe;
    logic [2:0] clockDivisorSelect;
    logic [1:0] accumulatorFlagClear, accumulatorFlagRegister;
    logic [3:0] channelDirectionSelect, compareActionModeBit;
    logic [3:0] compareActionLevelBit, captureEdgeRising, captureEdgeFalling;
    logic [3:0] forceCompareBit, channelIrqEnable, channelEventFlagClear;
    logic [3:0] ch7CompareMask, ch7CompareData, channelWriteStrobe;
    logic [3:0] portWriteValue, portWriteStrobe, channelPinIn, pinReq;
    logic [3:0] channelPinOut, channelEventFlag, channelIrq;
    logic [63:0] channelWriteValue, channelRegister;
    logic [15:0] timerCount, accumulatorCount, base, accumulatorWriteValue;
    logic [1:0] acts [3] = '{2'h3, 2'h2, 2'h1};
    int errors = 0;
    int n_tests = 0;

    always #12.5 clk = ~clk;

    tcc_pin_model tcc_pin_model_inst (.clk(clk), .pinReq(pinReq),
        .pinOut(channelPinIn));

    tcc_timer tcc_timer_inst (.clk(clk), .rst(rst),
        .timerEnable(timerEnable), .clockDivisorSelect(clockDivisorSelect),
        .counterResetOnCh7Enable(counterResetOnCh7Enable),
        .fastFlagClearEnable(fastFlagClearEnable),
        .counterOverflowFlagClear(counterOverflowFlagClear),
        .channelDirectionSelect(channelDirectionSelect),
        .compareActionModeBit(compareActionModeBit),
        .compareActionLevelBit(compareActionLevelBit),
        .captureEdgeRising(captureEdgeRising),
        .captureEdgeFalling(captureEdgeFalling),
        .forceCompareBit(forceCompareBit),
        .channelIrqEnable(channelIrqEnable),
        .channelEventFlagClear(channelEventFlagClear),
        .ch7CompareMask(ch7CompareMask), .ch7CompareData(ch7CompareData),
        .channelWriteValue(channelWriteValue),
        .channelWriteStrobe(channelWriteStrobe),
        .portWriteValue(portWriteValue), .portWriteStrobe(portWriteStrobe),
        .accumulatorEnable(accumulatorEnable),
        .accumulatorModeBit(accumulatorModeBit),
        .accumulatorEdgeSelect(accumulatorEdgeSelect),
        .accumulatorOverflowIrqEnable(accumulatorOverflowIrqEnable),
        .accumulatorInputIrqEnable(accumulatorInputIrqEnable),
        .accumulatorFlagClear(accumulatorFlagClear),
        .accumulatorCountAccess(accumulatorCountAccess),
        .accumulatorWriteValue(accumulatorWriteValue),
        .accumulatorWriteStrobe(accumulatorWriteStrobe),
        .channelPinIn(channelPinIn), .channelPinOut(channelPinOut),
        .timerCount(timerCount), .channelRegister(channelRegister),
        .channelEventFlag(channelEventFlag),
        .counterOverflowFlag(counterOverflowFlag),
        .accumulatorCount(accumulatorCount),
        .accumulatorFlagRegister(accumulatorFlagRegister),
        .channelIrq(channelIrq), .accumulatorInputIrq(accumulatorInputIrq),
        .accumulatorOverflowIrq(accumulatorOverflowIrq),
        .counterOverflowIrq(counterOverflowIrq));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // An unknown value fails the range test, never passes it.
    task automatic chk(input logic [15:0] got, input logic [15:0] lo,
                       input logic [15:0] hi, input string what);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic wrCh(input int i, input logic [15:0] v);
        channelWriteValue[16*i+:16] = v;
        channelWriteStrobe[i] = 1'b1;
        tick(1);
        channelWriteStrobe[i] = 1'b0;
    endtask
    task automatic act(input int i, input logic [1:0] a);
        compareActionModeBit[i] = a[1];
        compareActionLevelBit[i] = a[0];
    endtask
    // Pin changes get eight clocks: model hold plus synchronizer.
    task automatic pin(input int i, input logic v);
        pinReq[i] = v;
        tick(8);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {timerEnable, counterResetOnCh7Enable, fastFlagClearEnable,
            counterOverflowFlagClear, accumulatorEnable, accumulatorModeBit,
            accumulatorEdgeSelect, accumulatorOverflowIrqEnable,
            accumulatorInputIrqEnable, accumulatorCountAccess,
            clockDivisorSelect, accumulatorFlagClear, channelDirectionSelect,
            compareActionModeBit, compareActionLevelBit, captureEdgeRising,
            captureEdgeFalling, forceCompareBit, channelIrqEnable,
            channelEventFlagClear, ch7CompareMask, ch7CompareData,
            channelWriteStrobe, portWriteValue, portWriteStrobe, pinReq,
            channelWriteValue, accumulatorWriteStrobe,
            accumulatorWriteValue} = '0;
        tick(10);
        chk(timerCount | accumulatorCount, 0, 0, "reset counts");
        rst = 1'b0;
        timerEnable = 1'b1;
        for (int s = 0; s < 8; s++) begin
            clockDivisorSelect = 3'(s);
            tick(130);
            base = timerCount;
            tick(4 << s);
            chk(timerCount - base, 4, 4, "prescale ticks");
        end
        clockDivisorSelect = 3'h0;
        captureEdgeRising[0] = 1'b1;
        base = timerCount;
        pin(0, 1'b1);
        chk(channelEventFlag[0], 1, 1, "capture flag");
        chk(channelRegister[15:0], base + 1, base + 8, "capture");
        chk(channelIrq[0], 0, 0, "masked capture irq");
        channelIrqEnable[0] = 1'b1;
        tick(2);
        chk(channelIrq[0], 1, 1, "capture irq");
        captureEdgeFalling[0] = 1'b1;
        base = timerCount;
        pin(0, 1'b0);
        chk(channelRegister[15:0], base + 1, base + 8, "fall cap");
        channelDirectionSelect[1] = 1'b1;
        channelIrqEnable[1] = 1'b1;
        for (int k = 0; k < 3; k++) begin
            act(1, acts[k]);
            wrCh(1, timerCount + 16'h0014);
            tick(30);
            chk(channelPinOut[1], k != 1, k != 1, "cmp pin");
            chk(channelEventFlag[1], 1, 1, "cmp flag");
            chk(channelIrq[1], 1, 1, "cmp irq");
            channelEventFlagClear[1] = 1'b1;
            tick(1);
            channelEventFlagClear[1] = 1'b0;
            tick(1);
        end
        forceCompareBit[1] = 1'b1;
        tick(1);
        forceCompareBit[1] = 1'b0;
        tick(2);
        chk(channelPinOut[1], 0, 0, "forced toggle");
        chk(channelEventFlag[1], 0, 0, "force flag");
        portWriteValue[1] = 1'b1;
        portWriteStrobe[1] = 1'b1;
        tick(1);
        portWriteStrobe[1] = 1'b0;
        tick(2);
        chk(channelPinOut[1], 0, 0, "owned pin");
        act(1, 2'h0);
        tick(2);
        chk(channelPinOut[1], 1, 1, "latched value");
        channelDirectionSelect[3] = 1'b1;
        ch7CompareMask = 4'h4;
        ch7CompareData = 4'h4;
        counterResetOnCh7Enable = 1'b1;
        wrCh(3, timerCount + 16'h0014);
        tick(30);
        chk(channelPinOut[2], 1, 1, "ch7 override");
        chk(timerCount, 0, 16, "ch7 reset");
        chk(channelEventFlag[3], 1, 1, "ch7 flag");
        {ch7CompareMask, counterResetOnCh7Enable} = '0;
        channelDirectionSelect[3] = 1'b0;
        // Event counting with the timer stopped.
        timerEnable = 1'b0;
        {accumulatorEnable, accumulatorEdgeSelect} = 2'h3;
        accumulatorInputIrqEnable = 1'b1;
        for (int p = 0; p < 5; p++) begin
            if (p == 3) accumulatorEdgeSelect = 1'b0;
            pin(3, 1'b1);
            pin(3, 1'b0);
        end
        chk(accumulatorCount, 5, 5, "events");
        chk(accumulatorFlagRegister, 1, 1, "input flag");
        chk(accumulatorInputIrq, 1, 1, "input irq");
        accumulatorFlagClear = 2'h1;
        tick(1);
        accumulatorFlagClear = 2'h0;
        tick(2);
        chk(accumulatorFlagRegister, 0, 0, "flag clear");
        pin(3, 1'b1);
        pin(3, 1'b0);
        fastFlagClearEnable = 1'b1;
        accumulatorCountAccess = 1'b1;
        tick(1);
        accumulatorCountAccess = 1'b0;
        tick(2);
        chk(accumulatorFlagRegister, 0, 0, "fast clear");
        // Gated mode, high level active.
        accumulatorModeBit = 1'b1;
        base = accumulatorCount;
        pin(3, 1'b1);
        tick(200);
        chk(accumulatorCount, base, base, "gate no clock");
        timerEnable = 1'b1;
        tick(320);
        chk(accumulatorCount, base + 4, base + 6, "gated");
        pin(3, 1'b0);
        chk(accumulatorFlagRegister, 1, 1, "trailing edge");
        // Load the count just below wrap, then one falling edge wraps it.
        accumulatorModeBit = 1'b0;
        accumulatorOverflowIrqEnable = 1'b1;
        accumulatorWriteValue = 16'hFFFF;
        accumulatorWriteStrobe = 1'b1;
        tick(1);
        accumulatorWriteStrobe = 1'b0;
        pin(3, 1'b1);
        pin(3, 1'b0);
        chk(accumulatorCount, 0, 0, "acc wrap");
        chk(accumulatorFlagRegister[1], 1, 1, "acc overflow");
        chk(accumulatorOverflowIrq, 1, 1, "acc ovf irq");
        accumulatorEnable = 1'b0;
        for (int w = 0; w < 70000 && counterOverflowFlag !== 1'b1; w++)
            tick(1);
        chk(counterOverflowFlag, 1, 1, "timer wrap");
        chk(timerCount, 0, 2, "count after wrap");
        tick(1);
        chk(counterOverflowIrq, 1, 1, "overflow irq");
        counterOverflowFlagClear = 1'b1;
        tick(1);
        counterOverflowFlagClear = 1'b0;
        chk(counterOverflowFlag, 0, 0, "overflow clear");
        wrap_up();
    end
endmodule
